// file: design/smsc_pkg.sv
// smsc_pkg: register map, field positions, reset values and carrier types
// for the serial module spi core.
// assumes a single 50 MHz system clock and an 8-bit register port.
`default_nettype none

package smsc_pkg;

  // register offsets on the plain register port
  localparam int SMSC_AW = 3;
  localparam logic [2:0] SMSC_OFF_MODE = 3'h0;
  localparam logic [2:0] SMSC_OFF_CFG = 3'h1;
  localparam logic [2:0] SMSC_OFF_DATA = 3'h2;
  localparam logic [2:0] SMSC_OFF_IRQ_ST = 3'h3;
  localparam logic [2:0] SMSC_OFF_IRQ_MASK = 3'h4;

  // serial_mode_enable_control fields
  localparam int SMSC_MODE_HI = 7;
  localparam int SMSC_MODE_LO = 5;
  localparam int SMSC_DBNC_HI = 3;
  localparam int SMSC_DBNC_LO = 2;
  localparam int SMSC_EN_BIT = 1;
  localparam int SMSC_ICF_BIT = 0;

  // spi_config_and_flags fields
  localparam int SMSC_SPARE_HI = 7;
  localparam int SMSC_SPARE_LO = 6;
  localparam int SMSC_POL_BIT = 5;
  localparam int SMSC_EDGE_BIT = 4;
  localparam int SMSC_ORDER_BIT = 3;
  localparam int SMSC_SELECT_PIN_ENABLE_BIT = 2;
  localparam int SMSC_WRITE_COLLISION_FLAG_BIT = 1;
  localparam int SMSC_TRF_BIT = 0;

  // interrupt status and mask layout
  localparam int SMSC_IRQ_W = 3;
  localparam int SMSC_IRQ_TRF = 0;
  localparam int SMSC_IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int SMSC_IRQ_ICF = 2;

  // interface mode codes
  localparam logic [2:0] SMSC_MODE_DIV4 = 3'h0;
  localparam logic [2:0] SMSC_MODE_DIV16 = 3'h1;
  localparam logic [2:0] SMSC_MODE_DIV64 = 3'h2;
  localparam logic [2:0] SMSC_MODE_SUB = 3'h3;
  localparam logic [2:0] SMSC_MODE_TIMER = 3'h4;
  localparam logic [2:0] SMSC_MODE_SLAVE = 3'h5;

  // reset values
  localparam logic [2:0] SMSC_MODE_RST = 3'h7;
  localparam logic [7:0] SMSC_CFG_RST = 8'h00;
  localparam logic [2:0] SMSC_MASK_RST = 3'h0;

  // master clock division: half period counts in system clocks, minus one
  localparam int SMSC_DIV4 = 4;
  localparam int SMSC_DIV16 = 16;
  localparam int SMSC_DIV64 = 64;
  localparam logic [4:0] SMSC_HALF4_M1 = 5'(SMSC_DIV4 / 2 - 1);
  localparam logic [4:0] SMSC_HALF16_M1 = 5'(SMSC_DIV16 / 2 - 1);
  localparam logic [4:0] SMSC_HALF64_M1 = 5'(SMSC_DIV64 / 2 - 1);

  // transfer length
  localparam logic [3:0] SMSC_LAST_BIT = 4'h7;
  localparam logic [4:0] SMSC_LAST_EDGE = 5'h0F;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smsc_bus_req_t;

  typedef struct packed {
    logic sck_i;
    logic sdi_i;
    logic scs_n_i;
    logic sub_clk_i;
  } smsc_pins_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic sdo_o;
    logic sdo_oe_n;
    logic scs_n_o;
    logic scs_n_oe_n;
  } smsc_pins_out_t;

endpackage : smsc_pkg

`default_nettype wire

// file: design/smsc_sync.sv
// smsc_sync: two flip-flop synchroniser for asynchronous pin inputs.
// assumes each bit is an independent level; no word coherence is given.
`default_nettype none

module smsc_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_d,
  output logic [W-1:0] sync_q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_d;
      sync_q <= meta_q;
    end
  end

endmodule : smsc_sync

`default_nettype wire

// file: design/smsc_core.sv
// smsc_core: spi portion of the serial module, master and slave roles.
// assumes register port and ptm_tick on sys_clk; spi pins are asynchronous.
//
// Contract
// - full duplex; master starts every transfer and drives the clock
// - mode selector bits 7..5 pick spi role or non-spi operation
// - enable bit 1 switches the whole spi function on or off
// - select enable set uses select line; cleared leaves it floating
// - one select line only; extra slaves need general purpose pins
// - shift order bit 3 chooses lsb first or msb first
// - idle polarity bit 5 and edge bit 4 pick sampling edge
// - one eight-bit buffer holds byte to send and byte received
// - codes 0..2 divide by 4,16,64; 3 sub clock; 5 slave
// - complete flag sets at byte end, stays until software clears
// - buffer write during transfer is dropped and sets collision flag
// - slave select released early sets incomplete and complete flags
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`default_nettype none

module smsc_core
  import smsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire smsc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic ptm_tick,
  input wire smsc_pins_in_t pins_in,
  output smsc_pins_out_t pins_out,
  output logic irq
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MASTER,
    ST_SLAVE
  } smsc_state_t;

  function automatic logic out_bit(input logic [7:0] v, input logic msb);
    out_bit = msb ? v[7] : v[0];
  endfunction : out_bit

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic msb,
                                          input logic b);
    shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
  endfunction : shift_in

  function automatic logic [4:0] half_m1(input logic [2:0] m);
    unique case (m)
      SMSC_MODE_DIV4: half_m1 = SMSC_HALF4_M1;
      SMSC_MODE_DIV16: half_m1 = SMSC_HALF16_M1;
      default: half_m1 = SMSC_HALF64_M1;
    endcase
  endfunction : half_m1

  // control registers
  logic [2:0] mode_q;
  logic [1:0] dbnc_q;
  logic en_q;
  logic icf_q;
  logic [1:0] spare_q;
  logic pol_q;
  logic edge_q;
  logic order_q;
  logic select_pin_enable_q;
  logic write_collision_flag_q;
  logic trf_q;
  logic [SMSC_IRQ_W-1:0] irq_st_q;
  logic [SMSC_IRQ_W-1:0] irq_mask_q;

  // transfer engine
  smsc_state_t state_q;
  logic [7:0] shr_q;
  logic [3:0] bit_cnt_q;
  logic [4:0] edge_cnt_q;
  logic [4:0] div_cnt_q;
  logic pend_q;
  logic [2:0] msamp_q;
  logic [7:0] txs_q;
  logic sck_q;
  logic sdo_q;
  logic sck_prev_q;
  logic scs_prev_q;
  logic sub_prev_q;
  logic [7:0] rdata_q;
  logic irq_q;
  smsc_pins_out_t pins_q;

  // synchronised pins
  logic [3:0] sync_w;
  logic s_sck;
  logic s_sdi;
  logic s_scs_n;
  logic s_sub;

  smsc_sync #(
    .W(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_d({pins_in.sub_clk_i, pins_in.scs_n_i, pins_in.sdi_i, pins_in.sck_i}),
    .sync_q(sync_w)
  );

  assign s_sck = sync_w[0];
  assign s_sdi = sync_w[1];
  assign s_scs_n = sync_w[2];
  assign s_sub = sync_w[3];

  // role decode
  logic is_master;
  logic is_slave;
  assign is_master = en_q && (mode_q <= SMSC_MODE_TIMER);
  assign is_slave = en_q && (mode_q == SMSC_MODE_SLAVE);

  // slave select: ignored when the select pin function is off
  logic slave_sel;
  assign slave_sel = select_pin_enable_q ? !s_scs_n : 1'b1;

  // master clock tick source
  logic tick;
  always_comb begin
    unique case (mode_q)
      SMSC_MODE_SUB: tick = s_sub ^ sub_prev_q;
      SMSC_MODE_TIMER: tick = ptm_tick;
      default: tick = (div_cnt_q == half_m1(mode_q));
    endcase
  end

  // edge events, one decode for both roles
  logic m_edge;
  logic sl_edge;
  logic edge_ev;
  logic edge_rise;
  logic sample_on_rise;
  logic sample_ev;
  logic drive_ev;
  logic sl_start;
  // clock parks after sixteen toggles while the last capture drains
  assign m_edge = (state_q == ST_MASTER) && tick
                  && (edge_cnt_q != SMSC_LAST_EDGE + 5'h01);
  assign sl_edge = is_slave && slave_sel && (s_sck ^ sck_prev_q);
  assign sl_start = (state_q == ST_IDLE) && sl_edge;
  assign edge_ev = m_edge || sl_edge;
  assign edge_rise = m_edge ? !sck_q : s_sck;
  assign sample_on_rise = !(pol_q ^ edge_q);
  assign sample_ev = edge_ev && (edge_rise == sample_on_rise);
  assign drive_ev = edge_ev && (edge_rise != sample_on_rise);

  // completion and early release
  logic m_done;
  logic s_done;
  logic done;
  logic abort;
  assign m_done = (state_q == ST_MASTER) && (edge_cnt_q == SMSC_LAST_EDGE + 5'h01)
                  && (msamp_q[1:0] == 2'b00);
  assign s_done = (state_q == ST_SLAVE || sl_start) && sample_ev
                  && (bit_cnt_q == SMSC_LAST_BIT);
  assign done = m_done || s_done;
  assign abort = (state_q == ST_SLAVE) && select_pin_enable_q && s_scs_n && !scs_prev_q
                 && (bit_cnt_q != 4'h0) && !s_done;

  // register port decode
  logic busy;
  logic data_wr;
  logic data_ok;
  logic collide;
  logic mode_wr;
  logic cfg_wr;
  assign busy = (state_q != ST_IDLE) || sl_start;
  assign data_wr = bus_req.wr && (bus_req.addr == SMSC_OFF_DATA);
  assign data_ok = data_wr && !busy;
  assign collide = data_wr && busy;
  assign mode_wr = bus_req.wr && (bus_req.addr == SMSC_OFF_MODE);
  assign cfg_wr = bus_req.wr && (bus_req.addr == SMSC_OFF_CFG);

  // mode and enable register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= SMSC_MODE_RST;
      dbnc_q <= 2'h0;
      en_q <= 1'b0;
    end else if (mode_wr) begin
      mode_q <= bus_req.wdata[SMSC_MODE_HI:SMSC_MODE_LO];
      dbnc_q <= bus_req.wdata[SMSC_DBNC_HI:SMSC_DBNC_LO];
      en_q <= bus_req.wdata[SMSC_EN_BIT];
    end
  end

  // configuration bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spare_q <= SMSC_CFG_RST[SMSC_SPARE_HI:SMSC_SPARE_LO];
      pol_q <= SMSC_CFG_RST[SMSC_POL_BIT];
      edge_q <= SMSC_CFG_RST[SMSC_EDGE_BIT];
      order_q <= SMSC_CFG_RST[SMSC_ORDER_BIT];
      select_pin_enable_q <= SMSC_CFG_RST[SMSC_SELECT_PIN_ENABLE_BIT];
    end else if (cfg_wr) begin
      spare_q <= bus_req.wdata[SMSC_SPARE_HI:SMSC_SPARE_LO];
      pol_q <= bus_req.wdata[SMSC_POL_BIT];
      edge_q <= bus_req.wdata[SMSC_EDGE_BIT];
      order_q <= bus_req.wdata[SMSC_ORDER_BIT];
      select_pin_enable_q <= bus_req.wdata[SMSC_SELECT_PIN_ENABLE_BIT];
    end
  end

  // flags: a hardware set wins over a software write in the same cycle.
  // software may set the incomplete flag by hand without raising complete.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trf_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      icf_q <= 1'b0;
    end else begin
      trf_q <= done || abort || (cfg_wr ? bus_req.wdata[SMSC_TRF_BIT] : trf_q);
      write_collision_flag_q <= collide || (cfg_wr ? bus_req.wdata[SMSC_WRITE_COLLISION_FLAG_BIT] : write_collision_flag_q);
      icf_q <= abort || (mode_wr ? bus_req.wdata[SMSC_ICF_BIT] : icf_q);
    end
  end

  // interrupt status, write one to clear, and mask
  logic [SMSC_IRQ_W-1:0] irq_ev;
  logic [SMSC_IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_ev = '0;
    irq_ev[SMSC_IRQ_TRF] = done || abort;
    irq_ev[SMSC_IRQ_WRITE_COLLISION_FLAG] = collide;
    irq_ev[SMSC_IRQ_ICF] = abort;
    irq_clr = (bus_req.wr && bus_req.addr == SMSC_OFF_IRQ_ST)
              ? bus_req.wdata[SMSC_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_q <= SMSC_MASK_RST;
    end else if (bus_req.wr && bus_req.addr == SMSC_OFF_IRQ_MASK) begin
      irq_mask_q <= bus_req.wdata[SMSC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_mask_q);
    end
  end

  // transfer state: master starts on an accepted buffer write,
  // slave on the first clock edge seen while selected
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (data_ok && is_master) begin
            state_q <= ST_MASTER;
          end else if (sl_start && !s_done) begin
            state_q <= ST_SLAVE;
          end
        end
        ST_MASTER: begin
          if (m_done || !is_master) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SLAVE: begin
          if (s_done || abort || !is_slave) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // shared buffer: loaded by software, shifted by the link
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shr_q <= 8'h00;
    end else if (data_ok) begin
      shr_q <= bus_req.wdata;
    end else if (msamp_q[2] || (sample_ev && !m_edge)) begin
      shr_q <= shift_in(shr_q, order_q, s_sdi);
    end
  end

  // pin lag plus synchroniser: master sdi is taken three cycles after
  // its own sample edge, else fast rates would capture the previous bit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      msamp_q <= 3'h0;
    end else if (state_q != ST_MASTER) begin
      msamp_q <= 3'h0;
    end else begin
      msamp_q <= {msamp_q[1:0], m_edge && sample_ev};
    end
  end

  // transmit copy, so the late capture never holds up the next out bit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txs_q <= 8'h00;
    end else if (data_ok) begin
      txs_q <= bus_req.wdata;
    end else if (!busy) begin
      txs_q <= shr_q;
    end else if (sample_ev) begin
      txs_q <= shift_in(txs_q, order_q, 1'b0);
    end
  end

  // bit and edge counters
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_q <= 4'h0;
    end else if (done || abort || !busy) begin
      bit_cnt_q <= 4'h0;
    end else if (sample_ev) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      edge_cnt_q <= 5'h00;
    end else if (state_q != ST_MASTER || m_done) begin
      edge_cnt_q <= 5'h00;
    end else if (m_edge) begin
      edge_cnt_q <= edge_cnt_q + 5'h01;
    end
  end

  // master divider runs only while a byte is moving, to save power
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q <= 5'h00;
    end else if (state_q != ST_MASTER || tick) begin
      div_cnt_q <= 5'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end

  // master serial clock, parked at the idle level between bytes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_q <= 1'b1;
    end else if (state_q != ST_MASTER) begin
      sck_q <= !pol_q;
    end else if (m_edge) begin
      sck_q <= !sck_q;
    end
  end

  // data out: first bit presented before the first edge; a drive edge
  // only advances after a sample, so leading drive edges are harmless
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      if (!busy) begin
        pend_q <= 1'b0;
      end else if (sample_ev) begin
        pend_q <= 1'b1;
      end else if (drive_ev) begin
        pend_q <= 1'b0;
      end
      if (data_ok) begin
        sdo_q <= out_bit(bus_req.wdata, order_q);
      end else if (!busy) begin
        sdo_q <= out_bit(shr_q, order_q);
      end else if (drive_ev && pend_q) begin
        sdo_q <= out_bit(txs_q, order_q);
      end
    end
  end

  // edge detection history on synchronised pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_prev_q <= 1'b0;
      scs_prev_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= s_sck;
      scs_prev_q <= s_scs_n;
      sub_prev_q <= s_sub;
    end
  end

  // pin drivers; enables are active low, everything floats when off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pins_q <= '{sck_o: 1'b1, sck_oe_n: 1'b1, sdo_o: 1'b0, sdo_oe_n: 1'b1,
                  scs_n_o: 1'b1, scs_n_oe_n: 1'b1};
    end else begin
      pins_q.sck_o <= sck_q;
      pins_q.sck_oe_n <= !is_master;
      pins_q.sdo_o <= sdo_q;
      pins_q.sdo_oe_n <= !(is_master || (is_slave && slave_sel));
      pins_q.scs_n_o <= (state_q != ST_MASTER);
      pins_q.scs_n_oe_n <= !(is_master && select_pin_enable_q);
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        SMSC_OFF_MODE: rdata_q <= {mode_q, 1'b0, dbnc_q, en_q, icf_q};
        SMSC_OFF_CFG: rdata_q <= {spare_q, pol_q, edge_q, order_q, select_pin_enable_q,
                                  write_collision_flag_q, trf_q};
        SMSC_OFF_DATA: rdata_q <= shr_q;
        SMSC_OFF_IRQ_ST: rdata_q <= {5'h00, irq_st_q};
        SMSC_OFF_IRQ_MASK: rdata_q <= {5'h00, irq_mask_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign bus_rdata = rdata_q;
  assign pins_out = pins_q;
  assign irq = irq_q;

endmodule : smsc_core

`default_nettype wire

// file: verification/smsc_core_monitor.sv
// smsc_core_chk: port-level checks on smsc_core.
// assumes one clock domain and the register map of smsc_pkg.
`default_nettype none

module smsc_core_chk
  import smsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire smsc_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic ptm_tick,
  input wire smsc_pins_in_t pins_in,
  input wire smsc_pins_out_t pins_out,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic mode_wr, cfg_wr, mask_wr;
  logic [4:0] tog_q;
  assign mode_wr = bus_req.wr && bus_req.addr == SMSC_OFF_MODE;
  assign cfg_wr = bus_req.wr && bus_req.addr == SMSC_OFF_CFG;
  assign mask_wr = bus_req.wr && bus_req.addr == SMSC_OFF_IRQ_MASK;
  // clock toggles seen while select is low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) tog_q <= 5'h00;
    else if (pins_out.scs_n_o) tog_q <= 5'h00;
    else if ($changed(pins_out.sck_o)) tog_q <= tog_q + 5'h01;
  end
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its slot");
  a_irq_masked: assert property (mask_wr && bus_req.wdata[2:0] == 3'h0 ##1 !mask_wr |=> !irq)
    else $error("irq high with mask cleared");
  a_off_float: assert property (mode_wr && !bus_req.wdata[SMSC_EN_BIT] |-> ##2
    (pins_out.sck_oe_n && pins_out.sdo_oe_n && pins_out.scs_n_oe_n))
    else $error("pins driven while disabled");
  a_slave_no_clock: assert property (mode_wr && bus_req.wdata[7:5] == SMSC_MODE_SLAVE
    |-> ##2 pins_out.sck_oe_n)
    else $error("slave drives clock");
  a_select_float: assert property (cfg_wr && !bus_req.wdata[SMSC_SELECT_PIN_ENABLE_BIT]
    |-> ##2 pins_out.scs_n_oe_n)
    else $error("select driven while disabled");
  a_sck_half_min: assert property (!pins_out.sck_oe_n && $changed(pins_out.sck_o)
    |=> $stable(pins_out.sck_o))
    else $error("clock half period too short");
  a_bit_count: assert property (!$past(pins_out.scs_n_oe_n) && $rose(pins_out.scs_n_o)
    && !$past(mode_wr) && !$past(mode_wr, 2) |-> tog_q + 5'($changed(pins_out.sck_o)) == 5'h10)
    else $error("byte without sixteen clock edges");
  a_idle_clock: assert property (!pins_out.scs_n_oe_n && pins_out.scs_n_o
    && $past(pins_out.scs_n_o) && !$past(cfg_wr) && !$past(cfg_wr, 2)
    && !$past(mode_wr) && !$past(mode_wr, 2) |-> $stable(pins_out.sck_o))
    else $error("clock moves between bytes");
  c_irq: cover property (irq);
  c_frame_end: cover property ($rose(pins_out.scs_n_o));
  c_slave: cover property (mode_wr && bus_req.wdata[7:5] == SMSC_MODE_SLAVE);
endmodule : smsc_core_chk

bind smsc_core smsc_core_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .ptm_tick(ptm_tick), .pins_in(pins_in), .pins_out(pins_out),
  .irq(irq));

`default_nettype wire

// file: verification/smsc_spi_peer.sv
// smsc_spi_peer: behavioural far-side spi slave.
// assumes the bench gives it the same edge and order settings as the core.
`default_nettype none

module smsc_spi_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic samp_rise,
  input wire logic msb,
  input wire logic [7:0] tx,
  input wire logic [3:0] dly,
  output var logic miso,
  output var logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  function automatic logic pick(input logic [7:0] b, input int i);
    return msb ? b[7 - i] : b[i];
  endfunction : pick
  initial miso = 1'b0;
  // one select line, first bit ready before the first edge
  always @(negedge sel_n) begin
    cnt = 0;
    miso <= #(dly) pick(tx, 0);
  end
  // released line shows no stale value
  always @(posedge sel_n) miso <= ~miso;
  always @(sck) begin
    if (!sel_n && cnt < 8) begin
      if (sck === samp_rise) begin
        rx = msb ? {rx[6:0], mosi} : {mosi, rx[7:1]};
        cnt++;
      end else if (cnt > 0) miso <= #(dly) pick(tx, cnt);
    end
  end
endmodule : smsc_spi_peer

`default_nettype wire

// file: verification/testbench.sv
// testbench: random master and slave bytes through smsc_core with a peer.
// assumes the checker is bound to the core; 50 MHz clock.
`default_nettype none

module testbench
  import smsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, resetn = 0, ptm_tick = 0, sub_clk = 0, irq, pmiso, act = 0;
  logic tsck = 1, tsdi = 0, tscs_n = 1, pol = 0, edg = 0, msb = 0, select_pin_enable = 0;
  logic [7:0] bus_rdata, ptx = 0, prx, tx, got, r;
  logic [3:0] dly = 0;
  logic [31:0] rs = 27;
  int err_total = 0, n_tests = 0, tk = 0, wn;
  smsc_bus_req_t bus_req = '0;
  smsc_pins_in_t pi;
  smsc_pins_out_t po;
  assign pi = '{po.sck_oe_n ? tsck : po.sck_o, act ? pmiso : tsdi,
    po.scs_n_oe_n ? tscs_n : po.scs_n_o, sub_clk};
  smsc_core u_smsc_core (.sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .ptm_tick(ptm_tick), .pins_in(pi), .pins_out(po), .irq(irq));
  smsc_spi_peer peer (.sck(pi.sck_i), .mosi(po.sdo_o), .sel_n(select_pin_enable ? pi.scs_n_i : ~act),
    .samp_rise(pol == edg), .msb(msb), .tx(ptx), .dly(dly), .miso(pmiso), .rx(prx));
  always #10 sys_clk = ~sys_clk;
  // slow timer tick and sub clock, far below the core clock
  always @(posedge sys_clk) begin
    tk <= tk + 1;
    ptm_tick <= (tk % 3 == 0);
    if (tk % 5 == 0) sub_clk <= ~sub_clk;
  end
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(negedge sys_clk);
    chk(nm, e, bus_rdata);
  endtask : rchk
  task wait_irq();
    wn = 0;
    while (irq !== 1'b1 && wn < 4000) begin
      @(posedge sys_clk);
      wn++;
    end
    chk("irq", 8'h01, {7'h0, irq});
  endtask : wait_irq
  task irq_off(input string nm);
    repeat (2) @(negedge sys_clk);
    chk(nm, 8'h00, {7'h0, irq});
  endtask : irq_off
  // bench as spi master: idle high, sample on falling, msb first
  task sxfer(input logic [7:0] b, input int nb);
    tscs_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      tsdi <= b[7 - i];
      repeat (6) @(posedge sys_clk);
      got = {got[6:0], po.sdo_o};
      tsck <= 1'b0;
      repeat (6) @(posedge sys_clk);
      tsck <= 1'b1;
    end
    repeat (6) @(posedge sys_clk);
    tscs_n <= 1'b1;
    tsdi <= ~tsdi;
  endtask : sxfer
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    // whole run is under two thousand cycles; slowest byte is about 520
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) rchk("reset value", a[2:0], a == 0 ? 8'hE0 : 8'h00);
    wr(3'h6, 8'hFF);
    rchk("unmapped", 3'h6, 8'h00);
    wr(SMSC_OFF_IRQ_MASK, 8'h01);
    for (int m = 0; m < 5; m++) begin
      r = rnd();
      {pol, edg, msb, select_pin_enable, dly} = {r[3:0], r[4] ? 4'h9 : 4'h0};
      select_pin_enable = select_pin_enable | ~m[0];
      ptx = rnd();
      tx = m == 0 ? 8'h80 : rnd();
      wr(SMSC_OFF_CFG, {2'b00, pol, edg, msb, select_pin_enable, 2'b00});
      wr(SMSC_OFF_MODE, {m[2:0], 5'b00010});
      repeat (2) @(posedge sys_clk);
      act <= 1'b1;
      @(negedge sys_clk);
      chk("sck idle", {7'h0, ~pol}, {7'h0, po.sck_o});
      wr(SMSC_OFF_DATA, tx);
      wr(SMSC_OFF_DATA, ~tx);
      wait_irq();
      if (m < 3) chk("rate", 8'h01, 8'(wn >= (32 << (2 * m)) - 6 && wn <= (32 << (2 * m)) + 6));
      rchk("rx data", SMSC_OFF_DATA, ptx);
      chk("peer rx", tx, prx);
      rchk("flags", SMSC_OFF_CFG, {2'b00, pol, edg, msb, select_pin_enable, 2'b11});
      rchk("status", SMSC_OFF_IRQ_ST, 8'h03);
      wr(SMSC_OFF_IRQ_MASK, 8'h00);
      irq_off("masked irq");
      wr(SMSC_OFF_IRQ_ST, 8'h07);
      wr(SMSC_OFF_IRQ_MASK, 8'h01);
      irq_off("cleared irq");
      wr(SMSC_OFF_CFG, {2'b00, pol, edg, msb, select_pin_enable, 2'b00});
      act <= 1'b0;
    end
    // abort by disable: no flags may appear
    wr(SMSC_OFF_DATA, rnd());
    wr(SMSC_OFF_MODE, 8'h80);
    repeat (40) @(posedge sys_clk);
    rchk("abort status", SMSC_OFF_IRQ_ST, 8'h00);
    {pol, edg, msb, select_pin_enable} = 4'h7;
    tx = rnd();
    r = rnd();
    wr(SMSC_OFF_CFG, 8'h1C);
    wr(SMSC_OFF_MODE, 8'hA2);
    wr(SMSC_OFF_DATA, tx);
    sxfer(r, 8);
    wait_irq();
    chk("slave tx", tx, got);
    rchk("slave rx", SMSC_OFF_DATA, r);
    rchk("slave flags", SMSC_OFF_CFG, 8'h1D);
    wr(SMSC_OFF_IRQ_ST, 8'h07);
    wr(SMSC_OFF_CFG, 8'h1C);
    sxfer(rnd(), 3);
    repeat (6) @(posedge sys_clk);
    rchk("incomplete", SMSC_OFF_MODE, 8'hA3);
    rchk("incomplete st", SMSC_OFF_IRQ_ST, 8'h05);
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
